// *** tmw_timer16.sv ***
// 16-bit timer/counter: normal, clear-on-match and fast PWM modes,
// two compare channels with waveform output latches and pin drive.
// Assumes a same-clock register master and same-clock interrupt acks.
`timescale 1ns/1ps

// How it works
// - Output action zero leaves the channel latch untouched on a match.
// - A new output action applies from the next compare match.
// - Force strobe in non-PWM modes applies the action at once.
// - Counting depends on waveform mode only, never on output actions.
// - PWM: action picks polarity; non-PWM: set, clear or toggle.
// - Normal mode always counts up and wraps 0xFFFF to 0x0000.
// - Normal mode sets overflow flag as the counter becomes zero.
// - Overflow flag clears when its interrupt is executed.
// - Normal mode accepts counter writes at any time.
// - Clear-on-match clears counter at compare-A (4) or capture (12).
// - Clear-on-match top is unbuffered; missed top wraps through 0xFFFF.
// - Clear-on-match top hit sets compare-A or capture flag.
// - Action 1 on channel A toggles the latch each match, but not in PWM modes 5 to 7.
// - Pin shows the waveform only while its direction bit is output.
// - Clear-on-match sets overflow flag on the 0xFFFF to 0 pass.
// - Timer clock divides by 1, 8, 64, 256 or 1024.
// - Fast PWM counts bottom to top then restarts at bottom.
// - Non-inverting clears on match, sets at bottom; inverting opposite.
// - PWM top is 0xFF, 0x1FF, 0x3FF, capture or compare-A.
// - Fast PWM compare matches set the channel compare flag.
// - PWM compare values are double buffered, updated at top.
// - Match sets compare flag next tick; ack or write-one clears.
// - PWM sets overflow at top, plus compare-A (mode 15) or capture (14) flag.
module tmw_timer16 (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [2:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  input wire logic ACK_OVF,
  input wire logic ACK_CMPA,
  input wire logic ACK_CMPB,
  input wire logic ACK_CAPT,
  output logic [3:0] FLAGS,
  output logic [1:0] OC_O,
  output logic [1:0] OC_OE
);
  tmw_pkg::tmw_req_t req;
  logic [15:0] ctrl_r;
  logic [1:0] pindir_r;
  logic [15:0] cnt_r;
  logic [15:0] capt_r;
  logic [15:0] ocr_buf_r [2];
  logic [15:0] ocr_act_r [2];
  logic [1:0] latch_r;
  logic [3:0] flags_r;
  logic [9:0] pre_r;
  logic blk_r;
  logic tick;
  logic [3:0] mode;
  logic [2:0] psel;
  logic [1:0] act [2];
  logic pwm;
  logic [15:0] top;
  logic top_hit;
  logic [1:0] match;
  logic cnt_wr;
  logic [1:0] force_s;
  logic [3:0] ack;
  logic [3:0] set_f;
  logic flg_wr;

  function automatic logic is_pwm(input logic [3:0] m);
    is_pwm = (m == tmw_pkg::MODE_PWM8) || (m == tmw_pkg::MODE_PWM9) ||
      (m == tmw_pkg::MODE_PWM10) || (m == tmw_pkg::MODE_PWM_CAPT) ||
      (m == tmw_pkg::MODE_PWM_A);
  endfunction

  assign req = '{wr: WR, rd: RD, addr: ADDR, wdata: WDATA};
  assign mode = ctrl_r[tmw_pkg::CTRL_MODE_LSB +: 4];
  assign psel = ctrl_r[tmw_pkg::CTRL_PSEL_LSB +: 3];
  assign act[0] = ctrl_r[tmw_pkg::CTRL_ACTA_LSB +: 2];
  assign act[1] = ctrl_r[tmw_pkg::CTRL_ACTB_LSB +: 2];
  assign pwm = is_pwm(mode);
  assign cnt_wr = req.wr && (req.addr == tmw_pkg::OFS_COUNT);
  assign ack = {ACK_CAPT, ACK_CMPB, ACK_CMPA, ACK_OVF};
  assign flg_wr = req.wr && (req.addr == tmw_pkg::OFS_FLAGS);

  always_ff @(posedge REF_CLK) begin
    if (RST || psel == tmw_pkg::PS_STOP) begin
      pre_r <= 10'h000;
    end else begin
      pre_r <= pre_r + 10'h001;
    end
  end

  always_comb begin
    unique case (psel)
      tmw_pkg::PS_1: tick = 1'b1;
      tmw_pkg::PS_8: tick = (pre_r[2:0] == tmw_pkg::DIV_8_LAST[2:0]);
      tmw_pkg::PS_64: tick = (pre_r[5:0] == tmw_pkg::DIV_64_LAST[5:0]);
      tmw_pkg::PS_256: tick = (pre_r[7:0] == tmw_pkg::DIV_256_LAST[7:0]);
      tmw_pkg::PS_1024: tick = (pre_r == tmw_pkg::DIV_1024_LAST);
      default: tick = 1'b0;
    endcase
  end

  always_comb begin
    unique case (mode)
      tmw_pkg::MODE_CLR_A: top = ocr_act_r[0];
      tmw_pkg::MODE_PWM_A: top = ocr_act_r[0];
      tmw_pkg::MODE_CLR_CAPT: top = capt_r;
      tmw_pkg::MODE_PWM_CAPT: top = capt_r;
      tmw_pkg::MODE_PWM8: top = tmw_pkg::TOP_8;
      tmw_pkg::MODE_PWM9: top = tmw_pkg::TOP_9;
      tmw_pkg::MODE_PWM10: top = tmw_pkg::TOP_10;
      default: top = tmw_pkg::TOP_MAX;
    endcase
  end

  // A counter write blocks matches for one timer tick
  assign top_hit = (cnt_r == top) && !blk_r && (mode != tmw_pkg::MODE_NORMAL);

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ctrl_r <= tmw_pkg::CTRL_RESET;
      pindir_r <= 2'h0;
      capt_r <= 16'h0000;
    end else if (req.wr) begin
      // action takes hold immediately, used at next match
      if (req.addr == tmw_pkg::OFS_CTRL) begin
        ctrl_r <= req.wdata;
      end
      if (req.addr == tmw_pkg::OFS_CAPT) begin
        capt_r <= req.wdata;
      end
      if (req.addr == tmw_pkg::OFS_PINDIR) begin
        pindir_r <= req.wdata[1:0];
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      blk_r <= 1'b0;
    end else if (cnt_wr) begin
      blk_r <= 1'b1;
    end else if (tick) begin
      blk_r <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      cnt_r <= 16'h0000;
    end else if (cnt_wr) begin
      cnt_r <= req.wdata;
    end else if (tick) begin
      if (top_hit) begin
        cnt_r <= tmw_pkg::BOTTOM;
      end else begin
        cnt_r <= cnt_r + 16'h0001;
      end
    end
  end

  // Force strobe only counts in non-PWM modes
  assign force_s = (req.wr && req.addr == tmw_pkg::OFS_FORCE && !pwm) ?
    req.wdata[1:0] : 2'h0;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      assign match[ch] = (cnt_r == ocr_act_r[ch]) && !blk_r;

      always_ff @(posedge REF_CLK) begin
        if (RST) begin
          ocr_buf_r[ch] <= 16'h0000;
          ocr_act_r[ch] <= 16'h0000;
        end else begin
          if (req.wr && req.addr == tmw_pkg::OFS_CMPA + 3'(ch)) begin
            ocr_buf_r[ch] <= req.wdata;
          end
          if (req.wr && req.addr == tmw_pkg::OFS_CMPA + 3'(ch) && !pwm) begin
            ocr_act_r[ch] <= req.wdata;
          end else if (!pwm) begin
            ocr_act_r[ch] <= ocr_buf_r[ch];
          end else if (tick && top_hit) begin
            ocr_act_r[ch] <= ocr_buf_r[ch];
          end
        end
      end

      always_ff @(posedge REF_CLK) begin
        if (RST) begin
          latch_r[ch] <= 1'b0;
        end else if (force_s[ch]) begin
          unique case (act[ch])
            tmw_pkg::ACT_TOGGLE: latch_r[ch] <= !latch_r[ch];
            tmw_pkg::ACT_CLEAR: latch_r[ch] <= 1'b0;
            tmw_pkg::ACT_SET: latch_r[ch] <= 1'b1;
            tmw_pkg::ACT_NONE: latch_r[ch] <= latch_r[ch];
          endcase
        end else if (tick && !pwm && match[ch]) begin
          unique case (act[ch])
            tmw_pkg::ACT_TOGGLE: latch_r[ch] <= !latch_r[ch];
            tmw_pkg::ACT_CLEAR: latch_r[ch] <= 1'b0;
            tmw_pkg::ACT_SET: latch_r[ch] <= 1'b1;
            tmw_pkg::ACT_NONE: latch_r[ch] <= latch_r[ch];
          endcase
        end else if (tick && pwm) begin
          // Bottom wins over a match at top: compare equal to top holds
          unique case (act[ch])
            tmw_pkg::ACT_CLEAR: begin
              if (top_hit) begin
                latch_r[ch] <= 1'b1;
              end else if (match[ch]) begin
                latch_r[ch] <= 1'b0;
              end
            end
            tmw_pkg::ACT_SET: begin
              if (top_hit) begin
                latch_r[ch] <= 1'b0;
              end else if (match[ch]) begin
                latch_r[ch] <= 1'b1;
              end
            end
            tmw_pkg::ACT_TOGGLE: begin
              // Toggle only for channel A with a register top
              if (ch == 0 && match[ch] && (mode == tmw_pkg::MODE_PWM_A ||
                  mode == tmw_pkg::MODE_PWM_CAPT)) begin
                latch_r[ch] <= !latch_r[ch];
              end
            end
            tmw_pkg::ACT_NONE: latch_r[ch] <= latch_r[ch];
          endcase
        end
      end

      always_ff @(posedge REF_CLK) begin
        if (RST) begin
          OC_O[ch] <= 1'b0;
          OC_OE[ch] <= 1'b0;
        end else begin
          OC_O[ch] <= latch_r[ch];
          OC_OE[ch] <= pindir_r[ch] && (act[ch] != tmw_pkg::ACT_NONE);
        end
      end
    end
  endgenerate

  always_comb begin
    set_f = 4'h0;
    if (tick) begin
      if (pwm) begin
        set_f[tmw_pkg::FLG_OVF] = top_hit;
      end else begin
        set_f[tmw_pkg::FLG_OVF] = (cnt_r == tmw_pkg::TOP_MAX) && !top_hit;
      end
      set_f[tmw_pkg::FLG_CMPA] = match[0] ||
        (top_hit && (mode == tmw_pkg::MODE_CLR_A ||
        mode == tmw_pkg::MODE_PWM_A));
      set_f[tmw_pkg::FLG_CMPB] = match[1];
      set_f[tmw_pkg::FLG_CAPT] = top_hit &&
        (mode == tmw_pkg::MODE_CLR_CAPT || mode == tmw_pkg::MODE_PWM_CAPT);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      flags_r <= 4'h0;
    end else if (req.wr && req.addr == tmw_pkg::OFS_FLAGS) begin
      flags_r <= set_f | (flags_r & ~ack & ~req.wdata[3:0]);
    end else begin
      flags_r <= set_f | (flags_r & ~ack);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      FLAGS <= 4'h0;
    end else begin
      FLAGS <= flags_r;
    end
  end

  // Read data stands the cycle after the strobe only
  always_ff @(posedge REF_CLK) begin
    if (RST || !req.rd) begin
      RDATA <= 16'h0000;
    end else begin
      unique case (req.addr)
        tmw_pkg::OFS_CTRL: RDATA <= ctrl_r;
        tmw_pkg::OFS_FORCE: RDATA <= 16'h0000;
        tmw_pkg::OFS_COUNT: RDATA <= cnt_r;
        tmw_pkg::OFS_CMPA: RDATA <= ocr_buf_r[0];
        tmw_pkg::OFS_CMPB: RDATA <= ocr_buf_r[1];
        tmw_pkg::OFS_CAPT: RDATA <= capt_r;
        tmw_pkg::OFS_FLAGS: RDATA <= {12'h000, flags_r};
        tmw_pkg::OFS_PINDIR: RDATA <= {14'h0, pindir_r};
      endcase
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  sequence s_clean_tick;
    tick && !cnt_wr;
  endsequence

  sequence s_dir_off;
    (!pindir_r[0]) [*2];
  endsequence

  a_normal_wrap: assert property (
    s_clean_tick and (mode == tmw_pkg::MODE_NORMAL && cnt_r == 16'hFFFF)
    |=> cnt_r == 16'h0000 && flags_r[tmw_pkg::FLG_OVF])
    else $error("normal mode wrap or overflow flag wrong");

  a_clear_match: assert property (
    s_clean_tick and (mode == tmw_pkg::MODE_CLR_A &&
    cnt_r == ocr_act_r[0] && !blk_r)
    |=> cnt_r == 16'h0000 && flags_r[tmw_pkg::FLG_CMPA])
    else $error("clear-on-match did not clear or flag");

  a_hold_action: assert property (
    act[0] == tmw_pkg::ACT_NONE && !force_s[0] |=> $stable(latch_r[0]))
    else $error("latch moved with no output action");

  a_toggle_match: assert property (
    s_clean_tick and (!pwm && act[0] == tmw_pkg::ACT_TOGGLE && match[0] &&
    !force_s[0]) |=> latch_r[0] != $past(latch_r[0]))
    else $error("toggle on match missing");

  a_pwm_bottom: assert property (
    tick && pwm && act[1] == tmw_pkg::ACT_CLEAR && top_hit |=> latch_r[1])
    else $error("non-inverting output not set at bottom");

  a_tick_gate: assert property (
    !tick && !cnt_wr && !force_s[1] |=> $stable(cnt_r) &&
    $stable(latch_r[1]))
    else $error("counter or latch moved without a tick");

  a_pin_gate: assert property (
    s_dir_off |-> !OC_OE[0])
    else $error("pin driven with direction bit off");

  a_cmp_flag: assert property (
    tick && match[1] |=> flags_r[tmw_pkg::FLG_CMPB] ##1
    (flags_r[tmw_pkg::FLG_CMPB] || $past(ACK_CMPB) ||
    $past(flg_wr)))
    else $error("compare flag not set on match");

  a_pwm_buffer: assert property (
    pwm && !(tick && top_hit) |=> $stable(ocr_act_r[0]))
    else $error("active compare changed away from top");

  a_div_eight: assert property (
    tick && psel == tmw_pkg::PS_8 ##1 psel == tmw_pkg::PS_8
    |-> (!tick) [*7])
    else $error("divide-by-8 tick spacing wrong");
endmodule // tmw_timer16

// *** tmw_pkg.sv ***
// Constants and carrier types for the 16-bit timer mode engine.
// Assumes one 40 MHz clock and a word-indexed register port.
package tmw_pkg;
  // Register indices on the 3-bit register port
  localparam logic [2:0] OFS_CTRL = 3'h0;
  localparam logic [2:0] OFS_FORCE = 3'h1;
  localparam logic [2:0] OFS_COUNT = 3'h2;
  localparam logic [2:0] OFS_CMPA = 3'h3;
  localparam logic [2:0] OFS_CMPB = 3'h4;
  localparam logic [2:0] OFS_CAPT = 3'h5;
  localparam logic [2:0] OFS_FLAGS = 3'h6;
  localparam logic [2:0] OFS_PINDIR = 3'h7;
  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_PSEL_LSB = 4;
  localparam int CTRL_ACTA_LSB = 8;
  localparam int CTRL_ACTB_LSB = 10;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // Flag register bit positions
  localparam int FLG_OVF = 0;
  localparam int FLG_CMPA = 1;
  localparam int FLG_CMPB = 2;
  localparam int FLG_CAPT = 3;
  // Waveform modes handled here
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_CLR_A = 4'h4;
  localparam logic [3:0] MODE_PWM8 = 4'h5;
  localparam logic [3:0] MODE_PWM9 = 4'h6;
  localparam logic [3:0] MODE_PWM10 = 4'h7;
  localparam logic [3:0] MODE_CLR_CAPT = 4'hC;
  localparam logic [3:0] MODE_PWM_CAPT = 4'hE;
  localparam logic [3:0] MODE_PWM_A = 4'hF;
  // Fixed tops
  localparam logic [15:0] TOP_MAX = 16'hFFFF;
  localparam logic [15:0] TOP_8 = 16'h00FF;
  localparam logic [15:0] TOP_9 = 16'h01FF;
  localparam logic [15:0] TOP_10 = 16'h03FF;
  localparam logic [15:0] BOTTOM = 16'h0000;
  // Output action codes
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;
  // Prescaler selects
  localparam logic [2:0] PS_STOP = 3'h0;
  localparam logic [2:0] PS_1 = 3'h1;
  localparam logic [2:0] PS_8 = 3'h2;
  localparam logic [2:0] PS_64 = 3'h3;
  localparam logic [2:0] PS_256 = 3'h4;
  localparam logic [2:0] PS_1024 = 3'h5;
  localparam logic [9:0] DIV_8_LAST = 10'h007;
  localparam logic [9:0] DIV_64_LAST = 10'h03F;
  localparam logic [9:0] DIV_256_LAST = 10'h0FF;
  localparam logic [9:0] DIV_1024_LAST = 10'h3FF;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [15:0] wdata;
  } tmw_req_t;
endpackage

// *** tmw_pin_load.sv ***
// Port pin model: an external load with a pull-up on each timer pin.
// Assumes a pin is released whenever its output enable is low.
`timescale 1ns/1ps
module tmw_pin_load (
  input wire logic [1:0] drive,
  input wire logic [1:0] oe,
  output logic [1:0] level
);
  // A released pin floats up and never keeps the last driven value
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      level[i] = oe[i] ? drive[i] : 1'b1;
    end
  end
endmodule // tmw_pin_load

// *** tb_top.sv ***
// Self-checking bench for the 16-bit timer mode engine.
// Assumes a 40 MHz clock and a pull-up load on both timer pins.
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] ack = 4'h0;
  logic [15:0] rdata;
  logic [3:0] flags;
  logic [1:0] oc;
  logic [1:0] oc_oe;
  logic [1:0] pin;
  int bad_count = 0;
  int check_count = 0;
  logic [1:0] acts [5] = '{2'h2, 2'h3, 2'h0, 2'h1, 2'h1};
  logic exps [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
  logic [2:0] pss [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
  int divs [5] = '{1, 8, 64, 256, 1024};
  logic [3:0] modes [5] = '{4'h5, 4'h6, 4'h7, 4'hE, 4'hF};
  int tops [5] = '{255, 511, 1023, 19, 19};

  tmw_timer16 i_dut (
    .REF_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .ACK_OVF(ack[0]), .ACK_CMPA(ack[1]),
    .ACK_CMPB(ack[2]), .ACK_CAPT(ack[3]), .FLAGS(flags), .OC_O(oc),
    .OC_OE(oc_oe)
  );
  tmw_pin_load i_load (.drive(oc), .oe(oc_oe), .level(pin));

  initial begin
    forever #12.5 clk = ~clk;
  end

  function automatic logic [15:0] b16(input logic x);
    return {15'h0, x};
  endfunction
  function automatic logic [15:0] ctl(input logic [3:0] m,
      input logic [2:0] ps, input logic [1:0] a, input logic [1:0] b);
    return {4'h0, b, a, 1'b0, ps, m};
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Cycles until the channel output changes; bounded so a stuck pin ends
  task automatic span(input int ch, output int n);
    logic v;
    v = oc[ch];
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (oc[ch] === v && n < 5000);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    cyc(80000);
    bad_count++;
    $display("watchdog expired");
    report_and_stop();
  end

  initial begin
    logic [15:0] v;
    logic [1:0] pol;
    int n;
    int h;
    int l;
    int j;
    cyc(16);
    rst <= 1'b0;
    cyc(1);
    rd_reg(tmw_pkg::OFS_CTRL, v);
    chk(v, tmw_pkg::CTRL_RESET);
    chk({12'h000, flags}, 16'h0000);
    wr_reg(tmw_pkg::OFS_COUNT, 16'hFFFD);
    rd_reg(tmw_pkg::OFS_COUNT, v);
    chk(v, 16'hFFFD);
    wr_reg(tmw_pkg::OFS_CTRL, ctl(tmw_pkg::MODE_NORMAL, tmw_pkg::PS_1,
      2'h0, 2'h0));
    cyc(8);
    chk(b16(flags[tmw_pkg::FLG_OVF]), 16'h0001);
    rd_reg(tmw_pkg::OFS_COUNT, v);
    chk(b16(v < 16'h0010), 16'h0001);
    @(posedge clk);
    ack <= 4'hF;
    @(posedge clk);
    ack <= 4'h0;
    cyc(3);
    chk({12'h000, flags}, 16'h0000);
    $display("test normal done");
    for (int i = 0; i < 5; i++) begin
      wr_reg(tmw_pkg::OFS_CTRL, ctl(tmw_pkg::MODE_NORMAL, tmw_pkg::PS_STOP,
        acts[i], 2'h0));
      wr_reg(tmw_pkg::OFS_FORCE, 16'h0001);
      cyc(3);
      chk(b16(oc[0]), b16(exps[i]));
    end
    $display("test force done");
    wr_reg(tmw_pkg::OFS_COUNT, 16'h0000);
    wr_reg(tmw_pkg::OFS_CMPA, 16'h0002);
    wr_reg(tmw_pkg::OFS_PINDIR, 16'h0003);
    wr_reg(tmw_pkg::OFS_FLAGS, 16'h000F);
    for (int i = 0; i < 5; i++) begin
      wr_reg(tmw_pkg::OFS_CTRL, ctl(tmw_pkg::MODE_CLR_A, pss[i],
        tmw_pkg::ACT_TOGGLE, 2'h0));
      span(0, n);
      span(0, n);
      span(0, n);
      chk(n[15:0], 16'(3 * divs[i]));
      chk(b16(pin[0]), b16(oc[0]));
      chk(b16(oc_oe[0]), 16'h0001);
    end
    chk(b16(flags[tmw_pkg::FLG_CMPA]), 16'h0001);
    chk(b16(flags[tmw_pkg::FLG_OVF]), 16'h0000);
    wr_reg(tmw_pkg::OFS_PINDIR, 16'h0000);
    cyc(3);
    chk({14'h0, oc_oe}, 16'h0000);
    chk({14'h0, pin}, 16'h0003);
    wr_reg(tmw_pkg::OFS_CTRL, ctl(tmw_pkg::MODE_CLR_A, tmw_pkg::PS_1,
      tmw_pkg::ACT_NONE, 2'h0));
    cyc(2);
    v = b16(oc[0]);
    // 21 cycles is seven periods: a stray toggle always leaves odd parity
    cyc(21);
    chk(b16(oc[0]), v);
    rd_reg(tmw_pkg::OFS_COUNT, v);
    chk(b16(v < 16'h0003), 16'h0001);
    wr_reg(tmw_pkg::OFS_FLAGS, 16'h000F);
    wr_reg(tmw_pkg::OFS_COUNT, 16'hFFFE);
    cyc(8);
    // A count above top must run through 0xFFFF before it clears
    chk(b16(flags[tmw_pkg::FLG_OVF]), 16'h0001);
    chk(b16(flags[tmw_pkg::FLG_CMPA]), 16'h0001);
    rd_reg(tmw_pkg::OFS_COUNT, v);
    chk(b16(v < 16'h0003), 16'h0001);
    $display("test clear on match done");
    for (int k = 0; k < 10; k++) begin
      j = k / 2;
      pol = k[0] ? tmw_pkg::ACT_SET : tmw_pkg::ACT_CLEAR;
      wr_reg(tmw_pkg::OFS_CTRL, ctl(modes[j], tmw_pkg::PS_STOP, 2'h0, pol));
      wr_reg(tmw_pkg::OFS_COUNT, 16'h0000);
      // Register tops kept well above the smallest legal value
      wr_reg(tmw_pkg::OFS_CAPT, 16'h0013);
      wr_reg(tmw_pkg::OFS_CMPA, 16'h0013);
      wr_reg(tmw_pkg::OFS_CMPB, 16'h0004);
      wr_reg(tmw_pkg::OFS_CTRL, ctl(modes[j], tmw_pkg::PS_1, 2'h0, pol));
      wr_reg(tmw_pkg::OFS_FLAGS, 16'h000F);
      span(1, n);
      span(1, n);
      span(1, n);
      if (oc[1] !== 1'b1) begin
        span(1, n);
      end
      span(1, h);
      span(1, l);
      chk(h[15:0], k[0] ? 16'(tops[j] - 4) : 16'h0005);
      chk(16'(h + l), 16'(tops[j] + 1));
      chk(b16(flags[tmw_pkg::FLG_OVF]), 16'h0001);
      chk(b16(flags[tmw_pkg::FLG_CMPB]), 16'h0001);
      if (j == 3) begin
        chk(b16(flags[tmw_pkg::FLG_CAPT]), 16'h0001);
      end
      if (j == 4) begin
        chk(b16(flags[tmw_pkg::FLG_CMPA]), 16'h0001);
      end
    end
    $display("test fast pwm done");
    report_and_stop();
  end
endmodule // tb_top
